// ### rtl/ufc_defines.vh
// Constants for the UART flow, trigger and turn-around slice.
// Assumes plain include by bare name; definitions only.
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// Register offsets on the 4-bit parallel register address
`define UFC_OFS_FLOW_SEL      4'h0
`define UFC_OFS_RESUME_A      4'h1
`define UFC_OFS_RESUME_B      4'h2
`define UFC_OFS_STOP_A        4'h3
`define UFC_OFS_STOP_B        4'h4
`define UFC_OFS_TX_IRQ_LVL    4'h5
`define UFC_OFS_RX_IRQ_LVL    4'h6
`define UFC_OFS_FLOW_HIGH     4'h7
`define UFC_OFS_FLOW_LOW      4'h8
`define UFC_OFS_CLK_PRESCALE  4'h9
`define UFC_OFS_TURNAROUND    4'hA
`define UFC_OFS_ADV_FEATURE2  4'hB
`define UFC_OFS_MODE          4'hC
`define UFC_OFS_STATUS        4'hD

// Flow-select fields inside the enhanced feature register
`define UFC_FS_TX_HI          3
`define UFC_FS_TX_LO          2
`define UFC_FS_RX_HI          1
`define UFC_FS_RX_LO          0

// Advanced feature register two fields
`define UFC_AF2_MULTIDROP     0
`define UFC_AF2_DIR_SEL_DTR   3
`define UFC_AF2_DIR_PIN_EN    4
`define UFC_AF2_MASK          8'h19

// Mode register field: large FIFO mode
`define UFC_MODE_FIFO128      0

// Clock prescaler field
`define UFC_PRESCALE_MSB      3

// Reset values
`define UFC_RST_ZERO          8'h00
`define UFC_RST_LEVEL         8'h01
`define UFC_RST_FLOW_HIGH     8'h60
`define UFC_RST_FLOW_LOW      8'h20
`define UFC_RST_FIFO128       1'b1

// Level code meaning one entry besides its own value
`define UFC_LVL_ZERO_CODE     8'h00
`define UFC_LVL_ONE           8'h01

`endif

// ### rtl/ufc_pair_buf.v
// Two-entry buffer for flow characters going to the transmitter.
// Assumes both sides on clk; a stall on the drain side fills it.
`timescale 1ns/1ps
module ufc_pair_buf (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [7:0] in_data,
  output wire       out_valid,
  input  wire       out_ready,
  output wire [7:0] out_data
);
  reg [7:0] slot0_reg;
  reg [7:0] slot1_reg;
  reg [1:0] count_reg;
  wire      push;
  wire      pop;

  // Honest full and empty from the fill count
  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot0_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Slot 0 is always the head; slot 1 shifts down on a pop
  always @(posedge clk) begin
    if (sys_rst) begin
      slot0_reg <= 8'h00;
      slot1_reg <= 8'h00;
      count_reg <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_reg == 2'h0) slot0_reg <= in_data;
          else slot1_reg <= in_data;
          count_reg <= count_reg + 2'h1;
        end
        2'b01: begin
          slot0_reg <= slot1_reg;
          count_reg <= count_reg - 2'h1;
        end
        2'b11: begin
          if (count_reg == 2'h1) slot0_reg <= in_data;
          else begin
            slot0_reg <= slot1_reg;
            slot1_reg <= in_data;
          end
        end
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule

// ### rtl/ufc_turnaround.v
// Line driver turn-around timer for multidrop mode.
// Assumes tx_busy and bit_tick come from logic on clk.
`timescale 1ns/1ps
module ufc_turnaround (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       enable,
  input  wire       tx_busy,
  input  wire       bit_tick,
  input  wire [7:0] delay,
  output wire       drive_tx
);
  localparam [2:0] ST_RX  = 3'b001;
  localparam [2:0] ST_TX  = 3'b010;
  localparam [2:0] ST_CNT = 3'b100;

  reg [2:0] state_reg;
  reg [7:0] count_reg;

  // Receive direction whenever idle or the timer has run out
  assign drive_tx = (state_reg != ST_RX);

  // Count is in bit periods, so it only moves on the bit tick
  always @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_RX;
      count_reg <= 8'h00;
    end else if (!enable) begin
      state_reg <= ST_RX;
      count_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (tx_busy) state_reg <= ST_TX;
        end
        ST_TX: begin
          if (!tx_busy) begin
            count_reg <= delay;
            state_reg <= (delay == 8'h00) ? ST_RX : ST_CNT; // [RULE_12]
          end
        end
        ST_CNT: begin
          if (tx_busy) state_reg <= ST_TX;
          else if (bit_tick) begin
            count_reg <= count_reg - 8'h01; // [RULE_13]
            if (count_reg == 8'h01) state_reg <= ST_RX; // [RULE_12]
          end
        end
        default: state_reg <= ST_RX;
      endcase
    end
  end
endmodule

// ### rtl/ufc_top.v
// Flow-control selection, FIFO trigger levels, prescaler and
// multidrop line turn-around for one UART channel.
// Assumes FIFO counts, receive characters, tx_busy and bit_tick
// arrive from logic on clk; the host uses the parallel register port.
`timescale 1ns/1ps
`include "ufc_defines.vh"

// What this block does
// RULE_01: Upper select bits pick transmitted flow pairs
// RULE_02: Lower select bits pick compared receive pair
// RULE_03: Single tx pair, rx both: either char counts
// RULE_04: All bits set: both pairs sent, both required
// RULE_05: Host never sends flow characters as data
// RULE_06: Transmit trigger level 1..128, zero means one
// RULE_07: Receive trigger level 1..128, zero means one
// RULE_08: High threshold stops the remote transmitter
// RULE_09: Low threshold lets the remote resume
// RULE_10: Programmable levels only in large FIFO mode
// RULE_11: Prescaler low nibble, upper reserved, resets zero
// RULE_12: After last bit count down, then receive
// RULE_13: Turn-around delay counted in bit periods
// RULE_14: Flow select is low nibble, resets off
// RULE_15: Mode bit enables multidrop turn-around logic
// RULE_16: Select bit picks request or terminal pin
// RULE_17: Pin driven only when pin enable set
// RULE_18: Software keeps codes legal, low below high
module ufc_top (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [3:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] tx_fifo_count,
  input  wire [7:0] rx_fifo_count,
  input  wire       small_tx_hit,
  input  wire       small_rx_hit,
  output reg        tx_level_hit,
  output reg        rx_level_hit,
  input  wire       rx_char_valid,
  input  wire [7:0] rx_char_data,
  output reg        rx_char_is_flow,
  output reg        remote_stopped,
  output wire       tx_flow_valid,
  input  wire       tx_flow_ready,
  output wire [7:0] tx_flow_data,
  output reg        local_stop,
  output wire [3:0] clock_prescale_value,
  input  wire       tx_busy,
  input  wire       bit_tick,
  input  wire       rts_n_user,
  input  wire       dtr_n_user,
  output reg        rts_n,
  output reg        dtr_n
);
  localparam [2:0] SQ_IDLE = 3'b001;
  localparam [2:0] SQ_A    = 3'b010;
  localparam [2:0] SQ_B    = 3'b100;

  reg  [3:0] enhanced_feature_reg;
  reg  [7:0] resume_char_a;
  reg  [7:0] resume_char_b;
  reg  [7:0] stop_char_a;
  reg  [7:0] stop_char_b;
  reg  [7:0] tx_fifo_irq_level;
  reg  [7:0] rx_fifo_irq_level;
  reg  [7:0] flow_threshold_high;
  reg  [7:0] flow_threshold_low;
  reg  [3:0] clock_prescale;
  reg  [7:0] line_turnaround_delay;
  reg  [7:0] advanced_feature_reg_two;
  reg        fifo128_reg;
  reg  [2:0] seq_state_reg;
  reg        seq_stop_reg;
  reg        pend_stop_reg;
  reg        pend_resume_reg;
  reg        half_stop_reg;
  reg        half_resume_reg;
  reg  [7:0] status_next;
  reg        stop_evt;
  reg        resume_evt;
  reg        is_flow;
  reg        half_stop_next;
  reg        half_resume_next;
  reg        buf_valid;
  reg  [7:0] buf_data;
  wire       buf_ready;
  wire       tx_hi;
  wire       tx_lo;
  wire       rx_hi;
  wire       rx_lo;
  wire       tx_flow_on;
  wire       rx_need_both;
  wire       rx_either;
  wire       multidrop_mode_enable;
  wire       tx_direction_pin_enable;
  wire       dir_sel_dtr;
  wire       dir_own;
  wire       drive_tx;
  wire [7:0] tx_lvl;
  wire [7:0] rx_lvl;
  wire [7:0] hi_lvl;
  wire [7:0] lo_lvl;
  wire       m_ra;
  wire       m_rb;
  wire       m_sa;
  wire       m_sb;

  // Code zero means a level of one entry
  function [7:0] lvl_of;
    input [7:0] code;
    begin
      lvl_of = (code == `UFC_LVL_ZERO_CODE) ? `UFC_LVL_ONE : code;
    end
  endfunction

  assign tx_hi = enhanced_feature_reg[`UFC_FS_TX_HI];
  assign tx_lo = enhanced_feature_reg[`UFC_FS_TX_LO];
  assign rx_hi = enhanced_feature_reg[`UFC_FS_RX_HI];
  assign rx_lo = enhanced_feature_reg[`UFC_FS_RX_LO];
  assign tx_flow_on = tx_hi | tx_lo; // [RULE_01]
  // Both pairs required only with every select bit set
  assign rx_need_both = tx_hi & tx_lo & rx_hi & rx_lo; // [RULE_04]
  assign rx_either = rx_hi & rx_lo & ~rx_need_both; // [RULE_03]
  assign multidrop_mode_enable = advanced_feature_reg_two[`UFC_AF2_MULTIDROP];
  assign tx_direction_pin_enable = advanced_feature_reg_two[`UFC_AF2_DIR_PIN_EN];
  assign dir_sel_dtr = advanced_feature_reg_two[`UFC_AF2_DIR_SEL_DTR];
  assign dir_own = multidrop_mode_enable & tx_direction_pin_enable; // [RULE_15] [RULE_17]
  assign clock_prescale_value = clock_prescale;
  assign tx_lvl = lvl_of(tx_fifo_irq_level); // [RULE_06]
  assign rx_lvl = lvl_of(rx_fifo_irq_level); // [RULE_07]
  assign hi_lvl = lvl_of(flow_threshold_high);
  assign lo_lvl = lvl_of(flow_threshold_low);
  assign m_ra = (rx_char_data == resume_char_a);
  assign m_rb = (rx_char_data == resume_char_b);
  assign m_sa = (rx_char_data == stop_char_a);
  assign m_sb = (rx_char_data == stop_char_b);

  // Register writes; reserved bits are dropped on write
  always @(posedge clk) begin
    if (sys_rst) begin
      enhanced_feature_reg     <= 4'h0; // [RULE_14]
      resume_char_a            <= `UFC_RST_ZERO;
      resume_char_b            <= `UFC_RST_ZERO;
      stop_char_a              <= `UFC_RST_ZERO;
      stop_char_b              <= `UFC_RST_ZERO;
      tx_fifo_irq_level        <= `UFC_RST_LEVEL;
      rx_fifo_irq_level        <= `UFC_RST_LEVEL;
      flow_threshold_high      <= `UFC_RST_FLOW_HIGH;
      flow_threshold_low       <= `UFC_RST_FLOW_LOW;
      clock_prescale           <= 4'h0; // [RULE_11]
      line_turnaround_delay    <= `UFC_RST_ZERO;
      advanced_feature_reg_two <= `UFC_RST_ZERO;
      fifo128_reg              <= `UFC_RST_FIFO128;
    end else if (reg_wr) begin
      case (reg_addr)
        `UFC_OFS_FLOW_SEL:     enhanced_feature_reg <= reg_wdata[3:0]; // [RULE_14]
        `UFC_OFS_RESUME_A:     resume_char_a <= reg_wdata;
        `UFC_OFS_RESUME_B:     resume_char_b <= reg_wdata;
        `UFC_OFS_STOP_A:       stop_char_a <= reg_wdata;
        `UFC_OFS_STOP_B:       stop_char_b <= reg_wdata;
        `UFC_OFS_TX_IRQ_LVL:   tx_fifo_irq_level <= reg_wdata; // [RULE_06]
        `UFC_OFS_RX_IRQ_LVL:   rx_fifo_irq_level <= reg_wdata; // [RULE_07]
        `UFC_OFS_FLOW_HIGH:    flow_threshold_high <= reg_wdata; // [RULE_08]
        `UFC_OFS_FLOW_LOW:     flow_threshold_low <= reg_wdata; // [RULE_09]
        `UFC_OFS_CLK_PRESCALE: clock_prescale <= reg_wdata[`UFC_PRESCALE_MSB:0]; // [RULE_11]
        `UFC_OFS_TURNAROUND:   line_turnaround_delay <= reg_wdata; // [RULE_13]
        `UFC_OFS_ADV_FEATURE2: advanced_feature_reg_two <= reg_wdata & `UFC_AF2_MASK;
        `UFC_OFS_MODE:         fifo128_reg <= reg_wdata[`UFC_MODE_FIFO128];
        default:               fifo128_reg <= fifo128_reg;
      endcase
    end
  end

  // Status word gathered for the read mux
  always @* begin
    status_next = {1'b0, fifo128_reg, drive_tx, dir_own,
                   local_stop, remote_stopped, rx_level_hit, tx_level_hit};
  end

  // Read data is registered; unmapped offsets read as zero
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `UFC_OFS_FLOW_SEL:     reg_rdata <= {4'h0, enhanced_feature_reg};
        `UFC_OFS_RESUME_A:     reg_rdata <= resume_char_a;
        `UFC_OFS_RESUME_B:     reg_rdata <= resume_char_b;
        `UFC_OFS_STOP_A:       reg_rdata <= stop_char_a;
        `UFC_OFS_STOP_B:       reg_rdata <= stop_char_b;
        `UFC_OFS_TX_IRQ_LVL:   reg_rdata <= tx_fifo_irq_level;
        `UFC_OFS_RX_IRQ_LVL:   reg_rdata <= rx_fifo_irq_level;
        `UFC_OFS_FLOW_HIGH:    reg_rdata <= flow_threshold_high;
        `UFC_OFS_FLOW_LOW:     reg_rdata <= flow_threshold_low;
        `UFC_OFS_CLK_PRESCALE: reg_rdata <= {4'h0, clock_prescale}; // [RULE_11]
        `UFC_OFS_TURNAROUND:   reg_rdata <= line_turnaround_delay;
        `UFC_OFS_ADV_FEATURE2: reg_rdata <= advanced_feature_reg_two;
        `UFC_OFS_MODE:         reg_rdata <= {7'h00, fifo128_reg};
        `UFC_OFS_STATUS:       reg_rdata <= status_next;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // Trigger hits; small FIFO mode passes its own trigger through
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_level_hit <= 1'b0;
      rx_level_hit <= 1'b0;
    end else if (fifo128_reg) begin
      tx_level_hit <= (tx_fifo_count <= tx_lvl); // [RULE_06] [RULE_10]
      rx_level_hit <= (rx_fifo_count >= rx_lvl); // [RULE_07] [RULE_10]
    end else begin
      tx_level_hit <= small_tx_hit; // [RULE_10]
      rx_level_hit <= small_rx_hit;
    end
  end

  // Hysteresis between high and low thresholds; software keeps low
  // below high, otherwise resume requests would repeat each cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      local_stop <= 1'b0;
    end else if (!fifo128_reg) begin
      local_stop <= 1'b0; // [RULE_10]
    end else if (rx_fifo_count >= hi_lvl) begin
      local_stop <= 1'b1; // [RULE_08]
    end else if (rx_fifo_count < lo_lvl) begin
      local_stop <= 1'b0; // [RULE_09]
    end
  end

  // Pending stop/resume requests; a new edge beats the retire
  always @(posedge clk) begin
    if (sys_rst) begin
      pend_stop_reg   <= 1'b0;
      pend_resume_reg <= 1'b0;
    end else if (!tx_flow_on || !fifo128_reg) begin
      pend_stop_reg   <= 1'b0;
      pend_resume_reg <= 1'b0;
    end else begin
      if ((rx_fifo_count >= hi_lvl) && !local_stop) begin
        pend_stop_reg   <= 1'b1; // [RULE_08]
        pend_resume_reg <= 1'b0;
      end else if (local_stop && (rx_fifo_count < lo_lvl)) begin
        pend_resume_reg <= 1'b1; // [RULE_09]
        pend_stop_reg   <= 1'b0;
      end else if (seq_state_reg == SQ_IDLE) begin
        if (pend_stop_reg) pend_stop_reg <= 1'b0;
        else if (pend_resume_reg) pend_resume_reg <= 1'b0;
      end
    end
  end

  // Character sender; with both pairs selected the first goes out then the second
  always @(posedge clk) begin
    if (sys_rst) begin
      seq_state_reg <= SQ_IDLE;
      seq_stop_reg  <= 1'b0;
    end else begin
      case (seq_state_reg)
        SQ_IDLE: begin
          if (pend_stop_reg || pend_resume_reg) begin
            seq_stop_reg  <= pend_stop_reg;
            seq_state_reg <= tx_hi ? SQ_A : SQ_B; // [RULE_01]
          end
        end
        SQ_A: if (buf_ready) seq_state_reg <= tx_lo ? SQ_B : SQ_IDLE; // [RULE_01] [RULE_04]
        SQ_B: if (buf_ready) seq_state_reg <= SQ_IDLE;
        default: seq_state_reg <= SQ_IDLE;
      endcase
    end
  end

  // Character offered to the buffer from the sender state
  always @* begin
    buf_valid = (seq_state_reg != SQ_IDLE);
    case (seq_state_reg)
      SQ_A:    buf_data = seq_stop_reg ? stop_char_a : resume_char_a;
      SQ_B:    buf_data = seq_stop_reg ? stop_char_b : resume_char_b;
      default: buf_data = 8'h00;
    endcase
  end

  // Receive comparison; with both pairs the first half is remembered
  always @* begin
    stop_evt         = 1'b0;
    resume_evt       = 1'b0;
    is_flow          = 1'b0;
    half_stop_next   = half_stop_reg;
    half_resume_next = half_resume_reg;
    if (rx_char_valid) begin
      half_stop_next   = 1'b0;
      half_resume_next = 1'b0;
      if (rx_need_both) begin
        is_flow          = m_sa | m_ra | (half_stop_reg & m_sb) | (half_resume_reg & m_rb);
        stop_evt         = half_stop_reg & m_sb; // [RULE_04]
        resume_evt       = half_resume_reg & m_rb; // [RULE_04]
        half_stop_next   = m_sa;
        half_resume_next = m_ra;
      end else if (rx_either) begin
        stop_evt   = m_sa | m_sb; // [RULE_03]
        resume_evt = m_ra | m_rb; // [RULE_03]
        is_flow    = stop_evt | resume_evt;
      end else if (rx_hi) begin
        stop_evt   = m_sa; // [RULE_02]
        resume_evt = m_ra;
        is_flow    = stop_evt | resume_evt;
      end else if (rx_lo) begin
        stop_evt   = m_sb; // [RULE_02]
        resume_evt = m_rb;
        is_flow    = stop_evt | resume_evt;
      end
    end
  end

  // Remote flow state; reserved characters are never payload
  always @(posedge clk) begin
    if (sys_rst) begin
      half_stop_reg   <= 1'b0;
      half_resume_reg <= 1'b0;
      remote_stopped  <= 1'b0;
      rx_char_is_flow <= 1'b0;
    end else begin
      half_stop_reg   <= half_stop_next;
      half_resume_reg <= half_resume_next;
      rx_char_is_flow <= is_flow; // [RULE_05]
      if (!(rx_hi | rx_lo)) remote_stopped <= 1'b0; // [RULE_02]
      else if (stop_evt) remote_stopped <= 1'b1;
      else if (resume_evt) remote_stopped <= 1'b0;
    end
  end

  // Stall by the transmitter holds the sender, no character lost
  ufc_pair_buf u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   (buf_data),
    .out_valid (tx_flow_valid),
    .out_ready (tx_flow_ready),
    .out_data  (tx_flow_data)
  );

  ufc_turnaround u_turn (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .enable   (dir_own),
    .tx_busy  (tx_busy),
    .bit_tick (bit_tick),
    .delay    (line_turnaround_delay),
    .drive_tx (drive_tx)
  );

  // Direction pin: low means receive; other pin keeps its user level
  always @(posedge clk) begin
    if (sys_rst) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      rts_n <= (dir_own && !dir_sel_dtr) ? drive_tx : rts_n_user; // [RULE_16] [RULE_17]
      dtr_n <= (dir_own && dir_sel_dtr) ? drive_tx : dtr_n_user; // [RULE_16] [RULE_12]
    end
  end
endmodule

// ### dv/ufc_remote_model.sv
// Remote node model: takes flow characters, sends receive characters.
// Assumes the block's clk; stall lets the bench fill the buffer.
`timescale 1ns/1ps
module ufc_remote_model (
  input  wire       clk,
  input  wire       stall,
  input  wire       tx_flow_valid,
  output reg        tx_flow_ready,
  input  wire [7:0] tx_flow_data,
  output reg        rx_char_valid,
  output reg  [7:0] rx_char_data
);
  logic [7:0] got[$];
  initial begin
    tx_flow_ready = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data  = 8'h00;
  end
  // Random stalls, so a slow remote is seen as well as a prompt one
  always @(negedge clk) tx_flow_ready <= !stall && ($urandom % 3 != 0);
  // A character is taken only on an edge with valid and ready both high
  always @(posedge clk) if (tx_flow_valid && tx_flow_ready) got.push_back(tx_flow_data);
  // One character; data inverted after so stale values never match
  task automatic send_char(input logic [7:0] c);
    @(negedge clk);
    rx_char_valid = 1'b1;
    rx_char_data  = c;
    @(negedge clk);
    rx_char_valid = 1'b0;
    rx_char_data  = ~c;
  endtask
endmodule

// ### dv/ufc_chk.sv
// Port checks for the flow and turn-around slice.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module ufc_chk (
  input wire       clk,
  input wire       sys_rst,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       rx_char_valid,
  input wire       rx_char_is_flow,
  input wire       remote_stopped,
  input wire       tx_flow_valid,
  input wire       tx_flow_ready,
  input wire [7:0] tx_flow_data,
  input wire [3:0] clock_prescale_value,
  input wire       rts_n,
  input wire       dtr_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Reset state at first edge after release
  a_prescale_reset: assert property ($fell(sys_rst) |-> clock_prescale_value == 4'h0)
    else $error("prescaler not zero after reset");
  a_flow_off_reset: assert property ($fell(sys_rst) |-> !remote_stopped && !tx_flow_valid)
    else $error("flow active after reset");
  a_pins_reset: assert property ($fell(sys_rst) |-> rts_n && dtr_n)
    else $error("pin low after reset");
  // A stalled flow character must not change or vanish
  a_flow_char_hold: assert property (tx_flow_valid && !tx_flow_ready |=> tx_flow_valid && $stable(tx_flow_data))
    else $error("flow char lost in stall");
  // Receive events only follow a received character; read data moves only on a read, prescaler only on a write
  a_flow_flag_cause: assert property (rx_char_is_flow |-> $past(rx_char_valid))
    else $error("flow flag without character");
  a_stop_cause: assert property ($rose(remote_stopped) |-> $past(rx_char_valid))
    else $error("stop without character");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_prescale_write: assert property (!$stable(clock_prescale_value) |-> $past(reg_wr))
    else $error("prescaler moved unwritten");
endmodule

bind ufc_top ufc_chk chk_u (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid), .rx_char_is_flow(rx_char_is_flow),
  .remote_stopped(remote_stopped), .tx_flow_valid(tx_flow_valid),
  .tx_flow_ready(tx_flow_ready), .tx_flow_data(tx_flow_data),
  .clock_prescale_value(clock_prescale_value), .rts_n(rts_n), .dtr_n(dtr_n));

// ### dv/tb_top.sv
// Self-checking bench for the flow, trigger and turn-around slice.
// Assumes the remote model on the flow ports; inputs change at negedge.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] RA = 8'h11, RB = 8'h13, SA = 8'h91, SB = 8'h93, PL = 8'h41;
  logic       clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, stall = 0, tx_busy = 0;
  logic       small_tx_hit = 0, small_rx_hit = 0, bit_tick = 0, rts_n_user = 1, dtr_n_user = 1;
  logic [3:0] reg_addr = 0, clock_prescale_value;
  logic [7:0] reg_wdata = 0, reg_rdata, tx_fifo_count = 0, rx_fifo_count = 0, tx_flow_data;
  logic [7:0] rx_char_data, v, n, r, a, d, q[$];
  logic       tx_level_hit, rx_level_hit, rx_char_valid, rx_char_is_flow, remote_stopped;
  logic       tx_flow_valid, tx_flow_ready, local_stop, rts_n, dtr_n, on;
  logic [2:0] tk = 0;
  int         err_count = 0, cmp_count = 0, cyc = 0, ticks = 0, i, k, s;
  logic [7:0] rst_v[13] = '{0, 0, 0, 0, 0, 1, 1, 8'h60, 8'h20, 0, 0, 0, 1};
  logic [7:0] msk[12] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                          8'h0F, 8'hFF, 8'h19};
  logic [7:0] lv[3] = '{8'h00, 8'h01, 8'h80};
  logic [31:0] rxt[9] = '{{8'h02, SA, PL, 8'h1}, {8'h02, SB, PL, 8'h0}, {8'h01, SB, PL, 8'h1},
    {8'h01, SB, RB, 8'h0}, {8'h0B, SB, PL, 8'h1}, {8'h07, SA, PL, 8'h1},
    {8'h0F, SA, PL, 8'h0}, {8'h0F, SA, SB, 8'h1}, {8'h00, SA, PL, 8'h0}};
  logic [15:0] tat[5] = '{16'h1100, 16'h1103, 16'h1902, 16'h0102, 16'h1002};

  ufc_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_fifo_count(tx_fifo_count), .rx_fifo_count(rx_fifo_count),
    .small_tx_hit(small_tx_hit), .small_rx_hit(small_rx_hit), .tx_level_hit(tx_level_hit),
    .rx_level_hit(rx_level_hit), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_char_is_flow(rx_char_is_flow), .remote_stopped(remote_stopped),
    .tx_flow_valid(tx_flow_valid), .tx_flow_ready(tx_flow_ready), .tx_flow_data(tx_flow_data),
    .local_stop(local_stop), .clock_prescale_value(clock_prescale_value), .tx_busy(tx_busy),
    .bit_tick(bit_tick), .rts_n_user(rts_n_user), .dtr_n_user(dtr_n_user), .rts_n(rts_n),
    .dtr_n(dtr_n));
  ufc_remote_model rm_u (.clk(clk), .stall(stall), .tx_flow_valid(tx_flow_valid),
    .tx_flow_ready(tx_flow_ready), .tx_flow_data(tx_flow_data),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data));

  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Bit period of 8 cycles; ticks counted for turn-around
  always @(negedge clk) begin
    tk <= tk + 3'd1;
    bit_tick <= (tk == 3'd7);
  end
  always @(posedge clk) if (bit_tick) ticks++;
  // Hang guard, far above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  function automatic logic [7:0] eff(logic [7:0] c);
    return (c == 8'h00) ? 8'h01 : c;
  endfunction
  task automatic cmp(logic [7:0] g, logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [3:0] ad, logic [7:0] dt);
    @(negedge clk);
    reg_addr = ad;
    reg_wdata = dt;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(logic [3:0] ad, output logic [7:0] dt);
    @(negedge clk);
    reg_addr = ad;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    dt = reg_rdata;
  endtask
  task automatic waitn(int m);
    for (int j = 0; j < 300 && rm_u.got.size() < m; j++) @(negedge clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    s = $urandom(50);
    repeat (4) @(negedge clk);
    sys_rst = 0;
    // Reset values, then an unmapped read
    for (i = 0; i < 13; i++) begin
      rd(i, r);
      cmp(r, rst_v[i]);
    end
    rd(4'hE, r);
    cmp(r, 8'h00);
    // Random write, read back; reserved bits read zero
    for (i = 0; i < 12; i++) begin
      v = $urandom;
      wr(i, v);
      rd(i, r);
      cmp(r, v & msk[i]);
      if (i == 9) cmp(clock_prescale_value, v & 8'h0F);
    end
    wr(0, 0);
    wr(11, 0);
    // Trigger levels in large mode, boundary counts first
    for (i = 0; i < 30; i++) begin
      v = (i < 6) ? lv[i % 3] : $urandom % 129;
      n = (i < 6) ? eff(v) - (i / 3) : $urandom % 129;
      wr(5, v);
      wr(6, v);
      tx_fifo_count = n;
      rx_fifo_count = n;
      repeat (2) @(negedge clk);
      cmp(tx_level_hit, n <= eff(v));
      cmp(rx_level_hit, n >= eff(v));
    end
    // Small FIFO mode passes its trigger through
    wr(12, 0);
    small_tx_hit = 1;
    repeat (2) @(negedge clk);
    cmp({tx_level_hit, rx_level_hit}, 2'b10);
    wr(12, 1);
    small_tx_hit = 0;
    // Flow characters sent on threshold crossings
    rx_fifo_count = 0;
    wr(1, RA); wr(2, RB); wr(3, SA); wr(4, SB); wr(7, 8'h10); wr(8, 8'h08);
    for (i = 1; i < 4; i++) begin
      wr(0, i << 2);
      rm_u.got.delete();
      q = {};
      if (i[1]) q.push_back(SA);
      if (i[0]) q.push_back(SB);
      if (i[1]) q.push_back(RA);
      if (i[0]) q.push_back(RB);
      stall = 1;
      rx_fifo_count = 8'h10;
      repeat (12) @(negedge clk);
      cmp(rm_u.got.size(), 0);
      cmp(local_stop, 1);
      stall = 0;
      waitn(q.size() / 2);
      rx_fifo_count = 8'h08;
      repeat (12) @(negedge clk);
      cmp(rm_u.got.size(), q.size() / 2);
      rx_fifo_count = 8'h07;
      waitn(q.size());
      cmp(rm_u.got.size(), q.size());
      for (k = 0; k < q.size() && k < rm_u.got.size(); k++) cmp(rm_u.got[k], q[k]);
    end
    // Receive comparison per select code
    for (i = 0; i < 9; i++) begin
      wr(0, rxt[i][31:24]);
      rm_u.send_char(rxt[i][23:16]);
      rm_u.send_char(rxt[i][15:8]);
      repeat (2) @(negedge clk);
      cmp(remote_stopped, rxt[i][0]);
      wr(0, 0);
    end
    // Turn-around per mode, pin and delay
    for (i = 0; i < 5; i++) begin
      {a, d} = tat[i];
      on = a[0] && a[4];
      {dtr_n_user, rts_n_user} = $urandom;
      wr(10, d);
      wr(11, a);
      @(negedge clk);
      tx_busy = 1;
      repeat (3) @(negedge clk);
      cmp(a[3] ? dtr_n : rts_n, on ? 1'b1 : (a[3] ? dtr_n_user : rts_n_user));
      cmp(a[3] ? rts_n : dtr_n, a[3] ? rts_n_user : dtr_n_user);
      @(posedge clk iff bit_tick);
      @(negedge clk);
      tx_busy = 0;
      ticks = 0;
      for (k = 0; k < 200 && on && (a[3] ? dtr_n : rts_n) !== 1'b0; k++) @(negedge clk);
      if (on) cmp(ticks, d);
      if (on) cmp(a[3] ? dtr_n : rts_n, 0);
      if (!on) cmp(rts_n, rts_n_user);
    end
    conclude();
  end
endmodule
